// [lpmc_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module lpmc_ctrl #(
  parameter int unsigned DIV_W = lpmc_pkg::LPMC_DIV_W
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  // mode requests from the cpu core (one-cycle pulses)
  input  wire logic              slow_req_i,
  input  wire logic              run_req_i,
  input  wire logic              wait_instr_i,
  input  wire logic              halt_instr_i,
  input  wire logic              stop_req_i,
  // divider settings from the clock control unit
  input  wire logic [DIV_W-1:0]  slow_ratio_i,
  input  wire logic [DIV_W-1:0]  wait_ratio_i,
  // wake sources, plus the watchdog enable that blocks halt entry
  input  wire logic              irq_ack_i,
  input  wire logic              watchdog_en_i,
  input  wire logic              wakeup_pin_i,
  // clock enables
  output logic                   cpu_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   intc_clk_en_o,
  output logic                   fetch_en_o,
  // status
  output lpmc_pkg::lpmc_mode_t   mode_o
);

  import lpmc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // wake-up pin synchroniser

  logic [LPMC_SYNC_STAGES-1:0] wk_sync;
  logic                        wk_level;
  logic                        wk_event;
  logic                        wk_agree;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wk_sync <= '0;
    end else begin
      wk_sync <= {wk_sync[LPMC_SYNC_STAGES-2:0], wakeup_pin_i};
    end
  end

  // a change counts once stages two and three agree
  assign wk_agree = (wk_sync[LPMC_SYNC_STAGES-2] == wk_sync[LPMC_SYNC_STAGES-1]);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wk_level <= 1'b0;
    end else if (wk_agree) begin
      wk_level <= wk_sync[LPMC_SYNC_STAGES-1];
    end
  end

  // one-cycle wake on the agreed rising edge; a one-cycle glitch never agrees
  assign wk_event = wk_agree && wk_sync[LPMC_SYNC_STAGES-1] && !wk_level;

  //////////////////////////////////////////////////////////////////////////////
  // mode state machine

  lpmc_mode_t mode;
  lpmc_mode_t next_mode;

  always_comb begin
    next_mode = mode;
    case (mode)
      LPMC_RUN, LPMC_SLOW: begin
        if (halt_instr_i && !watchdog_en_i) begin
          next_mode = LPMC_HALT;
        end else if (stop_req_i) begin
          next_mode = LPMC_STOP;
        end else if (wait_instr_i) begin
          next_mode = LPMC_WAIT;
        end else if (slow_req_i) begin
          next_mode = LPMC_SLOW;
        end else if (run_req_i) begin
          next_mode = LPMC_RUN;
        end
      end
      LPMC_WAIT: begin
        if (irq_ack_i) begin
          next_mode = LPMC_RUN;
        end
      end
      LPMC_HALT: begin
        next_mode = LPMC_HALT;
      end
      LPMC_STOP: begin
        if (wk_event) begin
          next_mode = LPMC_RUN;
        end
      end
      default: begin
        next_mode = LPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode <= LPMC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock dividers

  logic slow_tick;
  logic wait_tick;

  lpmc_clk_div #(
    .DIV_W (DIV_W)
  ) u_slow_div (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ratio_i    (slow_ratio_i),
    .run_i      (mode == LPMC_SLOW),
    .tick_o     (slow_tick)
  );

  lpmc_clk_div #(
    .DIV_W (DIV_W)
  ) u_wait_div (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ratio_i    (wait_ratio_i),
    .run_i      (mode == LPMC_WAIT),
    .tick_o     (wait_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // clock enable decode, taken from the mode being entered so that
  // the enables change on the same edge as mode_o

  logic next_cpu_clk_en;
  logic next_periph_clk_en;
  logic next_intc_clk_en;
  logic next_fetch_en;

  always_comb begin
    next_cpu_clk_en    = 1'b0;
    next_periph_clk_en = 1'b0;
    next_intc_clk_en   = 1'b0;
    next_fetch_en      = 1'b0;
    case (next_mode)
      LPMC_RUN: begin
        next_cpu_clk_en    = 1'b1;
        next_periph_clk_en = 1'b1;
        next_intc_clk_en   = 1'b1;
        next_fetch_en      = 1'b1;
      end
      LPMC_SLOW: begin
        next_cpu_clk_en    = slow_tick;
        next_periph_clk_en = slow_tick;
        next_intc_clk_en   = slow_tick;
        next_fetch_en      = 1'b1;
      end
      LPMC_WAIT: begin
        next_cpu_clk_en    = 1'b0;
        next_periph_clk_en = wait_tick;
        next_intc_clk_en   = wait_tick;
        next_fetch_en      = 1'b0;
      end
      default: begin
        // halt and stop freeze everything
        next_cpu_clk_en    = 1'b0;
        next_periph_clk_en = 1'b0;
        next_intc_clk_en   = 1'b0;
        next_fetch_en      = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered clock enables, one flop each so no gated clock sees a glitch

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cpu_clk_en_o <= 1'b1;
    end else begin
      cpu_clk_en_o <= next_cpu_clk_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      periph_clk_en_o <= 1'b1;
    end else begin
      periph_clk_en_o <= next_periph_clk_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      intc_clk_en_o <= 1'b1;
    end else begin
      intc_clk_en_o <= next_intc_clk_en;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      fetch_en_o <= 1'b1;
    end else begin
      fetch_en_o <= next_fetch_en;
    end
  end

  assign mode_o = mode;

endmodule // lpmc_ctrl

`default_nettype wire

// [lpmc_pkg.sv]
package lpmc_pkg;

  // operating modes, gray coded along run -> slow -> wait -> halt -> stop
  typedef enum logic [2:0] {
    LPMC_RUN  = 3'h0,
    LPMC_SLOW = 3'h1,
    LPMC_WAIT = 3'h3,
    LPMC_HALT = 3'h2,
    LPMC_STOP = 3'h6
  } lpmc_mode_t;

  localparam int unsigned LPMC_DIV_W       = 8;
  localparam logic [7:0]  LPMC_DIV_RST     = 8'h01;
  localparam int unsigned LPMC_SYNC_STAGES = 3;
  localparam logic [7:0]  LPMC_CNT_ZERO    = 8'h00;

endpackage : lpmc_pkg

// [lpmc_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none

// turns a divide ratio into a one-cycle enable tick; ratio 0 or 1 ticks every cycle
module lpmc_clk_div #(
  parameter int unsigned DIV_W = 8
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  // control
  input  wire logic [DIV_W-1:0] ratio_i,
  input  wire logic             run_i,
  // output
  output logic                  tick_o
);

  logic [DIV_W-1:0] cnt;
  logic             wrap;

  assign wrap   = (cnt + DIV_W'(1) >= ratio_i);
  assign tick_o = run_i & wrap;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else if (!run_i || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + DIV_W'(1);
    end
  end

endmodule // lpmc_clk_div

`default_nettype wire

// [lpmc_ctrl_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl_checker
  import lpmc_pkg::*;
#(parameter int unsigned DIV_W = 8) (
  input wire logic core_clk_i, nrst_i, wait_instr_i, halt_instr_i, stop_req_i,
  input wire logic irq_ack_i, watchdog_en_i, wakeup_pin_i, cpu_clk_en_o,
  input wire logic periph_clk_en_o, fetch_en_o,
  input wire logic [DIV_W-1:0] slow_ratio_i,
  input wire lpmc_pkg::lpmc_mode_t mode_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire r = mode_o == LPMC_RUN;
  wire l = mode_o == LPMC_SLOW;
  wire w = mode_o == LPMC_WAIT;
  wire h = mode_o == LPMC_HALT;
  wire s = mode_o == LPMC_STOP;
  wire q = !cpu_clk_en_o && !periph_clk_en_o;
  ////////////////////////////////////////
  AST_RUN: assert property (r |-> cpu_clk_en_o && periph_clk_en_o && fetch_en_o)
    else $error("run gated");
  AST_SLOW: assert property (l && slow_ratio_i > 1 && cpu_clk_en_o |=> !(l && cpu_clk_en_o))
    else $error("slow too fast");
  AST_WIN: assert property ((r || l) && wait_instr_i && !halt_instr_i && !stop_req_i |=> w)
    else $error("wait not entered");
  AST_WAIT: assert property (w |-> !cpu_clk_en_o && !fetch_en_o) else $error("wait cpu");
  AST_WOUT: assert property (w && irq_ack_i |=> r) else $error("no wait exit");
  AST_HALT: assert property (h |-> q) else $error("halt running");
  AST_HOLD: assert property (h |=> h) else $error("halt left");
  AST_WDOG: assert property (!h && halt_instr_i && watchdog_en_i |=> !h) else $error("wd halt");
  AST_STOP: assert property (s |-> q && !fetch_en_o) else $error("stop running");
  AST_WAKE: assert property ((s && !wakeup_pin_i)[*3] ##1 (s && wakeup_pin_i)[*3]
    |-> ##[1:4] r) else $error("no wake");
  cover property (s ##[1:6] r);
  cover property (l && cpu_clk_en_o);
  cover property (w && irq_ack_i);
  cover property (h ##1 h);
endmodule // lpmc_ctrl_checker
bind lpmc_ctrl lpmc_ctrl_checker #(.DIV_W(DIV_W)) u_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .wait_instr_i(wait_instr_i),
  .halt_instr_i(halt_instr_i), .stop_req_i(stop_req_i), .irq_ack_i(irq_ack_i),
  .watchdog_en_i(watchdog_en_i), .wakeup_pin_i(wakeup_pin_i), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .fetch_en_o(fetch_en_o), .slow_ratio_i(slow_ratio_i),
  .mode_o(mode_o));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lpmc_pkg::*;
  logic clk = 0, nrst = 0, irq = 0, wd = 0, wk = 0;
  logic [4:0] rq = 0;
  logic [7:0] sr = 8'h02, wr = 8'h02;
  logic [15:0] lf = 16'hb575;
  wire cpu, per, ic, fe;
  wire lpmc_mode_t md;
  int fail_count = 0, check_count = 0, c, k;
  always #20 clk = ~clk;
  lpmc_ctrl dut (.core_clk_i(clk), .nrst_i(nrst), .slow_req_i(rq[0]), .run_req_i(rq[1]),
    .wait_instr_i(rq[2]), .halt_instr_i(rq[3]), .stop_req_i(rq[4]), .slow_ratio_i(sr),
    .wait_ratio_i(wr), .irq_ack_i(irq), .watchdog_en_i(wd), .wakeup_pin_i(wk),
    .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .intc_clk_en_o(ic), .fetch_en_o(fe),
    .mode_o(md));
  ////////////////////////////////////////
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // ticks seen in a window of n cycles at divide ratio r
  function automatic int ex(input int n, r);
    return n / r;
  endfunction
  task automatic chk(input logic [5:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pu(input logic [4:0] v);
    rq = v;
    cy(1);
    rq = 0;
  endtask
  // skip one period, then count enables over four periods
  task automatic tk(input int r, input bit m, input int e);
    cy(r);
    k = 0;
    repeat (4 * r) begin
      k += m ? per + ic : cpu;
      cy(1);
    end
    chk(6'(k), 6'(e));
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    summarize;
  end
  initial begin
    cy(4);
    nrst = 1;
    chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
    for (c = 0; c < 3; c++) begin
      lf = nx(lf);
      // last pass is the divide-by-one corner
      sr = (c == 2) ? 8'h01 : 8'h02 + 8'(lf[1:0]);
      wr = 8'h02 + 8'(lf[3:2]);
      pu(5'h01);
      chk({md, cpu, per, fe}, {LPMC_SLOW, 3'h1});
      tk(sr, 0, ex(4 * sr, sr));
      if (c == 1) begin
        pu(5'h02);
        chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
        cy(1);
      end
      pu(5'h06);
      chk({md, cpu, per, fe}, {LPMC_WAIT, 3'h0});
      tk(wr, 1, 2 * ex(4 * wr, wr));
      pu(5'h19);
      chk({md, cpu, fe, 1'b0}, {LPMC_WAIT, 3'h0});
      irq = 1;
      cy(1);
      irq = 0;
      chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
      pu(5'h14);
      chk({md, cpu, per, fe}, {LPMC_STOP, 3'h0});
      cy(1);
      irq = 1;
      pu(5'h0b);
      irq = 0;
      chk({md, cpu, per, fe}, {LPMC_STOP, 3'h0});
      cy(1);
      wk = 1;
      k = 0;
      while (md !== LPMC_RUN && k < 10) begin
        cy(1);
        k++;
      end
      chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
      wk = 0;
      cy(4);
    end
    wd = 1;
    pu(5'h08);
    chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
    cy(1);
    wd = 0;
    pu(5'h08);
    chk({md, cpu, per, fe}, {LPMC_HALT, 3'h0});
    irq = 1;
    wk = 1;
    pu(5'h01);
    cy(6);
    chk({md, cpu, per, fe}, {LPMC_HALT, 3'h0});
    nrst = 0;
    cy(1);
    nrst = 1;
    chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
    cy(2);
    chk({md, cpu, per, fe}, {LPMC_RUN, 3'h7});
    summarize;
  end
endmodule // tb
`default_nettype wire
